// ---- core/pfc_defines.svh ----
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH
`define PFC_OFF_CPU_HI 8'h0f
`define PFC_OFF_SRC_N 8'h10
`define PFC_OFF_CTRL 8'h11
`define PFC_OFF_DRIVE 8'h12
`define PFC_CPU_N8_BIT 7
`define PFC_SMOOTH_SWITCH_ENABLE_BIT 7
`define PFC_SMOOTH_SWITCH_TARGET_BIT 6
`define PFC_SRC_EN_BIT 4
`define PFC_CPU_EN_BIT 3
`define PFC_CTRL_MASK 8'hd8
`define PFC_RST_CPU_HI 8'h00
`define PFC_RST_SRC_N 8'h00
`define PFC_RST_CTRL 8'h00
`define PFC_RST_DRIVE 8'h40
`endif

// ---- core/pfc_pkg.sv ----
package pfc_pkg;
	typedef logic [7:0] pfc_byte_t;
	typedef enum logic [1:0] {
		PFC_SW_CPU = 2'b01,
		PFC_SW_SRC = 2'b10
	} pfc_sw_target_t;
endpackage

// ---- core/pfc_freq_ctrl.sv ----
`timescale 1ns/1ps
`include "pfc_defines.svh"
// Behaviour
// - CPU feedback divider bit 8 lives in bit 7 of byte 0x0f.
// - CPU enable set: CPU uses nine-bit N (stored bit 8 over i_cpu_n_low) and stored seven-bit M.
// - Ratio select from latched straps, or software field when override set.
// - SRC enable set: SRC uses stored eight-bit N value.
// - Control bit 7 enables smooth switching; resets to zero.
// - Control bit 6 routes smooth switch: 0 CPU, 1 SRC.
// - Control bit 4 enables programmed SRC frequency; default off.
// - Control bit 3 enables programmed CPU frequency; default off.
// - Smooth switch disabled: circuit follows the PLL being overclocked.
module pfc_freq_ctrl import pfc_pkg::*; #(
	parameter int N_W = 9,
	parameter int M_W = 7
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// Register port
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] i_cpu_n_low,
	output logic [7:0] o_reg_rdata,
	// Strap and ratio inputs
	input wire logic [2:0] i_latched_strap_select,
	input wire logic [2:0] i_software_ratio_select,
	input wire logic i_ratio_source_override,
	input wire logic [N_W-1:0] i_table_cpu_n,
	input wire logic [M_W-1:0] i_table_cpu_m,
	input wire logic [7:0] i_table_src_n,
	// PLL steering
	output logic [N_W-1:0] o_cpu_feedback_div,
	output logic [M_W-1:0] o_cpu_reference_div,
	output logic [7:0] o_src_feedback_div,
	output logic [2:0] o_ratio_select,
	output logic o_smooth_switch_on,
	output logic o_smooth_to_src,
	output logic [7:0] o_drive_strength
);
	// Register file and its read path
	pfc_byte_t cpu_hi_r;
	pfc_byte_t src_n_r;
	pfc_byte_t ctrl_r;
	pfc_byte_t drive_r;
	pfc_byte_t rdata_nxt;
	pfc_sw_target_t target;

	// Strap and select levels may come from another domain
	localparam int SYNC_W = 7;
	wire [SYNC_W-1:0] async_in = {i_ratio_source_override, i_software_ratio_select, i_latched_strap_select};
	wire [SYNC_W-1:0] sync_out;
	wire [2:0] strap_s = sync_out[2:0];
	wire [2:0] sw_sel_s = sync_out[5:3];
	wire ovr_s = sync_out[6];

	// Write strobes per mapped offset; unmapped offsets are ignored
	wire wr_cpu_hi = i_reg_wr && (i_reg_addr == `PFC_OFF_CPU_HI);
	wire wr_src_n = i_reg_wr && (i_reg_addr == `PFC_OFF_SRC_N);
	wire wr_ctrl = i_reg_wr && (i_reg_addr == `PFC_OFF_CTRL);
	wire wr_drive = i_reg_wr && (i_reg_addr == `PFC_OFF_DRIVE);
	// Reserved control bits are dropped on entry, so they can only read back as zero
	wire [7:0] cpu_hi_nxt = wr_cpu_hi ? i_reg_wdata : cpu_hi_r;
	wire [7:0] src_n_nxt = wr_src_n ? i_reg_wdata : src_n_r;
	wire [7:0] ctrl_nxt = wr_ctrl ? (i_reg_wdata & `PFC_CTRL_MASK) : ctrl_r;
	// Drive fields are stored as written and passed out unchanged
	wire [7:0] drive_nxt = wr_drive ? i_reg_wdata : drive_r;

	// PLL steering selection
	wire cpu_prog = ctrl_r[`PFC_CPU_EN_BIT];
	wire src_prog = ctrl_r[`PFC_SRC_EN_BIT];
	wire [N_W-1:0] cpu_n_prog = {cpu_hi_r[`PFC_CPU_N8_BIT], i_cpu_n_low};
	wire [M_W-1:0] cpu_m_prog = cpu_hi_r[M_W-1:0];
	wire [N_W-1:0] cpu_fb_nxt = cpu_prog ? cpu_n_prog : i_table_cpu_n;
	wire [M_W-1:0] cpu_ref_nxt = cpu_prog ? cpu_m_prog : i_table_cpu_m;
	wire [7:0] src_fb_nxt = src_prog ? src_n_r : i_table_src_n;
	wire [2:0] ratio_nxt = ovr_s ? sw_sel_s : strap_s;
	wire smooth_switch_enable = ctrl_r[`PFC_SMOOTH_SWITCH_ENABLE_BIT];
	// Auto mode favours CPU when both PLLs are overclocked at once
	wire auto_src = src_prog && !cpu_prog;
	wire to_src = smooth_switch_enable ? ctrl_r[`PFC_SMOOTH_SWITCH_TARGET_BIT] : auto_src;
	// Any programmed PLL keeps the shared circuit in use, even in auto mode
	wire smooth_on_nxt = smooth_switch_enable || cpu_prog || src_prog;
	wire to_src_nxt = (target == PFC_SW_SRC);

	assign target = to_src ? PFC_SW_SRC : PFC_SW_CPU;

	// Unmapped offsets read zero
	always_comb begin
		rdata_nxt = 8'h00;
		if (i_reg_addr == `PFC_OFF_CPU_HI) begin
			rdata_nxt = cpu_hi_r;
		end else if (i_reg_addr == `PFC_OFF_SRC_N) begin
			rdata_nxt = src_n_r;
		end else if (i_reg_addr == `PFC_OFF_CTRL) begin
			rdata_nxt = ctrl_r;
		end else if (i_reg_addr == `PFC_OFF_DRIVE) begin
			rdata_nxt = drive_r;
		end
	end

	// Two flops per bit; only the second one is read by logic
	genvar g;
	generate
		for (g = 0; g < SYNC_W; g++) begin : g_sync
			logic s1_r;
			logic s2_r;
			always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
				end else begin
					s1_r <= async_in[g];
					s2_r <= s1_r;
				end
			end
			assign sync_out[g] = s2_r;
		end
	endgenerate

	// Host registers
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cpu_hi_r <= `PFC_RST_CPU_HI;
		end else begin
			cpu_hi_r <= cpu_hi_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			src_n_r <= `PFC_RST_SRC_N;
		end else begin
			src_n_r <= src_n_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctrl_r <= `PFC_RST_CTRL;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			drive_r <= `PFC_RST_DRIVE;
		end else begin
			drive_r <= drive_nxt;
		end
	end

	// Outputs come straight from flops; steering lags a write by two edges
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_reg_rdata <= 8'h00;
		end else begin
			o_reg_rdata <= rdata_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_cpu_feedback_div <= '0;
		end else begin
			o_cpu_feedback_div <= cpu_fb_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_cpu_reference_div <= '0;
		end else begin
			o_cpu_reference_div <= cpu_ref_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_src_feedback_div <= 8'h00;
		end else begin
			o_src_feedback_div <= src_fb_nxt;
		end
	end

	// Ratio follows its inputs three edges late: two sync flops plus this one
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_ratio_select <= 3'h0;
		end else begin
			o_ratio_select <= ratio_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_smooth_switch_on <= 1'b0;
		end else begin
			o_smooth_switch_on <= smooth_on_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_smooth_to_src <= 1'b0;
		end else begin
			o_smooth_to_src <= to_src_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_drive_strength <= `PFC_RST_DRIVE;
		end else begin
			o_drive_strength <= drive_r;
		end
	end
endmodule

// ---- verification/pfc_host.sv ----
`timescale 1ns/1ps
module pfc_host (
	input wire logic i_ref_clk,
	output logic o_wr = 1'b0,
	output logic [7:0] o_a = 8'h00,
	output logic [7:0] o_d = 8'h00
);
	// Whole byte per access, so M and the high N bit always move together
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		{o_wr, o_a, o_d} <= {1'b1, a, d};
		@(posedge i_ref_clk);
		{o_wr, o_d} <= {1'b0, ~d};
	endtask
	// Two edges: one for the registered mux, one so steering outputs settle too
	task automatic rd(input logic [7:0] a);
		@(posedge i_ref_clk);
		o_a <= a;
		repeat (2) @(posedge i_ref_clk);
	endtask
endmodule

// ---- verification/pfc_freq_ctrl_properties.sv ----
`timescale 1ns/1ps
module pfc_chk import pfc_pkg::*; #(parameter int N_W = 9, parameter int M_W = 7) (
	input wire logic i_ref_clk, i_sys_rst, i_reg_wr, i_ratio_source_override, o_smooth_switch_on, o_smooth_to_src,
	input wire logic [2:0] i_latched_strap_select, i_software_ratio_select, o_ratio_select,
	input wire logic [7:0] i_reg_addr, i_reg_wdata, i_cpu_n_low, i_table_src_n, o_reg_rdata, o_src_feedback_div,
	input wire logic [N_W-1:0] i_table_cpu_n, o_cpu_feedback_div,
	input wire logic [M_W-1:0] i_table_cpu_m, o_cpu_reference_div
);
	logic rst_d;
	logic [7:0] hi_r, sn_r, ct_r, dv_r, rd_w;
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			{rst_d, hi_r, sn_r, ct_r, dv_r} <= {1'b1, 24'h000000, 8'h40};
		end else begin
			rst_d <= 1'b0;
			if (i_reg_wr && i_reg_addr == 8'h0f) hi_r <= i_reg_wdata;
			if (i_reg_wr && i_reg_addr == 8'h10) sn_r <= i_reg_wdata;
			if (i_reg_wr && i_reg_addr == 8'h11) ct_r <= i_reg_wdata & 8'hd8;
			if (i_reg_wr && i_reg_addr == 8'h12) dv_r <= i_reg_wdata;
		end
	end
	assign rd_w = i_reg_addr == 8'h0f ? hi_r : i_reg_addr == 8'h10 ? sn_r :
		i_reg_addr == 8'h11 ? ct_r : i_reg_addr == 8'h12 ? dv_r : 8'h00;
	default clocking cb @(posedge i_ref_clk); endclocking
	// First edge after release still sees reset-time outputs
	default disable iff (i_sys_rst || rst_d);
	sequence s_quiet;
		($stable(i_latched_strap_select) && $stable(i_software_ratio_select) && $stable(i_ratio_source_override)) [*4];
	endsequence
	chk_cpu_div: assert property (
		o_cpu_feedback_div == $past(ct_r[3] ? {hi_r[7], i_cpu_n_low} : i_table_cpu_n)) else $error("cpu N");
	chk_cpu_ref: assert property (
		o_cpu_reference_div == $past(ct_r[3] ? hi_r[6:0] : i_table_cpu_m)) else $error("cpu M");
	chk_src_div: assert property (
		o_src_feedback_div == $past(ct_r[4] ? sn_r : i_table_src_n)) else $error("src N");
	chk_smsw_on: assert property (o_smooth_switch_on == $past(|(ct_r & 8'h98))) else $error("smooth on");
	chk_smsw_target: assert property (
		o_smooth_to_src == $past(ct_r[7] ? ct_r[6] : ct_r[4] & !ct_r[3])) else $error("smooth target");
	chk_ratio_select: assert property (s_quiet |-> o_ratio_select ==
		(i_ratio_source_override ? i_software_ratio_select : i_latched_strap_select)) else $error("ratio");
	chk_read_back: assert property (o_reg_rdata == $past(rd_w)) else $error("readback");
	chk_rsvd_zero: assert property ($past(i_reg_addr) == 8'h11 |-> !(o_reg_rdata & 8'h27)) else $error("rsvd");
endmodule
bind pfc_freq_ctrl pfc_chk #(.N_W(N_W), .M_W(M_W)) i_chk (.*);

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
	logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, wr, ov = 1'b0, on, ts;
	logic [2:0] rs, sw = 3'h2, st = 3'h5;
	logic [6:0] cm, tm = 7'h11;
	logic [7:0] a, d, rdat, sn, dv, nl = 8'h5a, tsn = 8'h64;
	logic [8:0] cn, tn = 9'h123;
	int mismatches = 0, checks_done = 0;
	always #5 i_ref_clk = ~i_ref_clk;
	pfc_host i_host (.i_ref_clk(i_ref_clk), .o_wr(wr), .o_a(a), .o_d(d));
	pfc_freq_ctrl i_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(wr), .i_reg_addr(a), .i_reg_wdata(d),
		.i_cpu_n_low(nl), .o_reg_rdata(rdat), .i_latched_strap_select(st), .i_software_ratio_select(sw),
		.i_ratio_source_override(ov), .i_table_cpu_n(tn), .i_table_cpu_m(tm), .i_table_src_n(tsn),
		.o_cpu_feedback_div(cn), .o_cpu_reference_div(cm), .o_src_feedback_div(sn), .o_ratio_select(rs),
		.o_smooth_switch_on(on), .o_smooth_to_src(ts), .o_drive_strength(dv));
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task summarize;
		if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#20000;
		mismatches++;
		summarize;
	end
	initial begin
		repeat (12) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			i_host.rd(8'(8'h0f + i));
			chk("reset", rdat, i == 3 ? 16'h0040 : 16'h0000);
		end
		chk("ratio", rs, 3'h5);
		i_host.wr(8'h0f, 8'ha5);
		i_host.wr(8'h10, 8'h3c);
		i_host.wr(8'h11, 8'hff);
		i_host.rd(8'h11);
		chk("ctrl", rdat, 8'hd8);
		chk("cpu n", cn, 9'h15a);
		chk("cpu m", cm, 7'h25);
		chk("smooth", {on, ts, sn}, {2'b11, 8'h3c});
		nl <= 8'hc3;
		i_host.wr(8'h11, 8'h18);
		i_host.rd(8'h11);
		chk("auto cpu", {on, ts, cn}, {2'b10, 9'h1c3});
		i_host.wr(8'h11, 8'h10);
		i_host.rd(8'h20);
		chk("auto src", {on, ts, sn, cn}, {2'b11, 8'h3c, 9'h123});
		chk("unmapped", rdat, 8'h00);
		i_host.wr(8'h11, 8'h40);
		i_host.rd(8'h11);
		chk("off", {on, ts, sn, cm}, {2'b00, 8'h64, 7'h11});
		{tn, tm, tsn, st} <= {9'h0c7, 7'h3e, 8'h81, 3'h3};
		i_host.wr(8'h12, 8'h9b);
		i_host.rd(8'h12);
		chk("drive", {rdat, dv}, 16'h9b9b);
		chk("table", {cn, cm, sn}, {9'h0c7, 7'h3e, 8'h81});
		chk("strap", rs, 3'h3);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		i_host.rd(8'h11);
		chk("rerun", {rdat, dv, on, ts, cn}, {8'h00, 8'h40, 2'b00, 9'h0c7});
		@(posedge i_ref_clk);
		{ov, sw} <= {1'b1, 3'h6};
		repeat (5) @(posedge i_ref_clk);
		chk("override", rs, 3'h6);
		summarize;
	end
endmodule
